// ### sflash_pkg.sv
// Shared constants, types and helpers for the serial flash pin front end.
package sflash_pkg;

  // ==========================================================================
  // Array organisation and counts
  // ==========================================================================
  localparam int          PAGE_COUNT   = 65536;
  localparam logic [8:0]  BYTE_CAP     = 9'h100;
  localparam logic [4:0]  OPC_LAST     = 5'h07;
  localparam logic [4:0]  ADDR_BITS    = 5'h18;
  localparam logic [4:0]  BYTE_BITS    = 5'h08;
  localparam logic [23:0] MASK_4K      = 24'hFFF000;
  localparam logic [23:0] MASK_32K     = 24'hFF8000;
  localparam logic [23:0] MASK_64K     = 24'hFF0000;
  localparam logic [23:0] PROG_CYCLES  = 24'h0001F4;
  localparam logic [23:0] ERASE_CYCLES = 24'h001388;

  // ==========================================================================
  // Instruction codes of this front end
  // ==========================================================================
  localparam logic [7:0] OPC_READ      = 8'h11;
  localparam logic [7:0] OPC_READ_TWO  = 8'h12;
  localparam logic [7:0] OPC_READ_FOUR = 8'h14;
  localparam logic [7:0] OPC_PROG      = 8'h21;
  localparam logic [7:0] OPC_PROG_FOUR = 8'h24;
  localparam logic [7:0] OPC_ERASE_4K  = 8'h31;
  localparam logic [7:0] OPC_ERASE_32K = 8'h32;
  localparam logic [7:0] OPC_ERASE_64K = 8'h33;
  localparam logic [7:0] OPC_ERASE_ALL = 8'h34;
  localparam logic [7:0] OPC_READ_UID  = 8'h41;
  localparam logic [7:0] OPC_OTP_PROG  = 8'h51;
  localparam logic [7:0] OPC_OTP_READ  = 8'h52;
  localparam logic [7:0] OPC_WR_STATUS = 8'h61;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [3:0] {
    K_NONE, K_READ, K_PROG, K_ERASE_4K, K_ERASE_32K, K_ERASE_64K,
    K_ERASE_ALL, K_UID, K_OTP_PROG, K_OTP_READ, K_WRSR
  } op_kind_type;

  typedef enum logic [1:0] {
    LN_ONE  = 2'h0,
    LN_TWO  = 2'h1,
    LN_FOUR = 2'h2
  } lane_type;

  typedef enum logic [2:0] {
    PH_OPC  = 3'h0,
    PH_ADR  = 3'h1,
    PH_DIN  = 3'h3,
    PH_DOUT = 3'h2,
    PH_DONE = 3'h6
  } phase_type;

  typedef struct packed {
    op_kind_type kind;
    lane_type    lanes;
    logic        has_addr;
    logic        rd;
    logic        wr;
  } op_info_type;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic op_info_type decode_op(input logic [7:0] opc);
    op_info_type i;
    i = '{K_NONE, LN_ONE, 1'b0, 1'b0, 1'b0};
    case (opc)
      OPC_READ:      i = '{K_READ, LN_ONE, 1'b1, 1'b1, 1'b0};
      OPC_READ_TWO:  i = '{K_READ, LN_TWO, 1'b1, 1'b1, 1'b0};
      OPC_READ_FOUR: i = '{K_READ, LN_FOUR, 1'b1, 1'b1, 1'b0};
      OPC_PROG:      i = '{K_PROG, LN_ONE, 1'b1, 1'b0, 1'b1};
      OPC_PROG_FOUR: i = '{K_PROG, LN_FOUR, 1'b1, 1'b0, 1'b1};
      OPC_ERASE_4K:  i = '{K_ERASE_4K, LN_ONE, 1'b1, 1'b0, 1'b0};
      OPC_ERASE_32K: i = '{K_ERASE_32K, LN_ONE, 1'b1, 1'b0, 1'b0};
      OPC_ERASE_64K: i = '{K_ERASE_64K, LN_ONE, 1'b1, 1'b0, 1'b0};
      OPC_ERASE_ALL: i = '{K_ERASE_ALL, LN_ONE, 1'b0, 1'b0, 1'b0};
      OPC_READ_UID:  i = '{K_UID, LN_ONE, 1'b0, 1'b1, 1'b0};
      OPC_OTP_PROG:  i = '{K_OTP_PROG, LN_ONE, 1'b1, 1'b0, 1'b1};
      OPC_OTP_READ:  i = '{K_OTP_READ, LN_ONE, 1'b1, 1'b1, 1'b0};
      OPC_WR_STATUS: i = '{K_WRSR, LN_ONE, 1'b0, 1'b0, 1'b1};
      default:       i = '{K_NONE, LN_ONE, 1'b0, 1'b0, 1'b0};
    endcase
    return i;
  endfunction

  function automatic logic [4:0] lane_bits(input lane_type ln);
    case (ln)
      LN_TWO:  lane_bits = 5'h02;
      LN_FOUR: lane_bits = 5'h04;
      default: lane_bits = 5'h01;
    endcase
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] x,
                                           input lane_type    ln,
                                           input logic [3:0]  pins);
    case (ln)
      LN_TWO:  shift_in = {x[21:0], pins[1:0]};
      LN_FOUR: shift_in = {x[19:0], pins};
      default: shift_in = {x[22:0], pins[0]};
    endcase
  endfunction

endpackage

// ### sflash_page_mem.sv
// Page buffer of one program unit, written and read on the serial clock.
module sflash_page_mem (
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata
);

  logic [7:0] mem_ff [256];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
    rdata <= mem_ff[raddr];
  end

endmodule

// ### sflash_front.sv
// Pin front end of the serial flash: lanes, select, pause and command hand-over.
// Behaviour
// - While select is high every lane driver is off.
// - A running erase, program or status write finishes even if select rises.
// - No instruction is taken until select has fallen once after reset.
// - In single-lane mode bits are taken from lane0 on rising serial clock edges.
// - In single-lane mode read bits leave on lane1 and change on falling edges.
// - Dual and quad lanes are sampled on rising and driven on falling edges.
// - Quad instructions need four_lane_enable, which turns lane2 and lane3 into data.
// - A low write-protect level with status_lock_bits[0] set refuses status writes.
// - A low pause level while selected freezes the shifter and turns drivers off.
// - The pause role of lane3 exists only while four_lane_enable is clear.
// - The array has 65,536 pages of 256 bytes and a program carries at most 256 bytes.
// - Erase works on 4KB sectors, 32KB and 64KB blocks, and the whole chip.
// - A 64-bit serial number and three 256-byte security areas are provided.
// - Serial clock modes 0 and 3 are both accepted.
module sflash_front #(
  parameter logic [23:0] ERASE_CYCLES = sflash_pkg::ERASE_CYCLES,
  parameter logic [23:0] PROG_CYCLES  = sflash_pkg::PROG_CYCLES,
  parameter logic [63:0] UNIQUE_ID    = 64'h0123_4567_89AB_CDEF // Arbitrary value.
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    lane0_in,
  output logic                         lane0_out,
  output logic                         lane0_oe,
  input  wire logic                    lane1_in,
  output logic                         lane1_out,
  output logic                         lane1_oe,
  input  wire logic                    lane2_in,
  output logic                         lane2_out,
  output logic                         lane2_oe,
  input  wire logic                    lane3_in,
  output logic                         lane3_out,
  output logic                         lane3_oe,
  input  wire logic                    four_lane_enable,
  input  wire logic [1:0]              status_lock_bits,
  output logic                         busy,
  output logic                         op_start,
  output sflash_pkg::op_kind_type      op_kind,
  output logic [23:0]                  op_addr,
  output logic [8:0]                   op_bytes,
  output logic [1:0]                   otp_area,
  output logic                         status_write_refused
);

  // ==========================================================================
  // State types
  // ==========================================================================
  typedef struct packed {
    sflash_pkg::phase_type   phase;
    logic [4:0]              bitcnt;
    logic [7:0]              opcode;
    logic [23:0]             addr;
    sflash_pkg::op_kind_type kind;
    sflash_pkg::lane_type    lanes;
    logic                    rd;
    logic                    wr;
    logic [7:0]              col;
    logic [8:0]              nbytes;
    logic                    complete;
  } rise_type;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } fall_type;

  typedef struct packed {
    sflash_pkg::op_kind_type kind;
    logic [23:0]             addr;
    logic [8:0]              nbytes;
    logic                    tog;
  } frame_type;

  typedef struct packed {
    logic                    tog_s1;
    logic                    tog_s2;
    logic                    tog_s3;
    logic                    seen;
    logic                    wp_s1;
    logic                    wp_s2;
    logic                    wp_s3;
    logic                    wp_held;
    logic                    busy;
    logic [23:0]             cnt;
    logic                    start;
    logic                    refused;
    sflash_pkg::op_kind_type kind;
    logic [23:0]             addr;
    logic [8:0]              bytes;
    logic [1:0]              area;
  } core_type;

  rise_type                rise_ff;
  rise_type                nxt_rise;
  fall_type                fall_ff;
  fall_type                nxt_fall;
  frame_type               frame_ff;
  core_type                core_ff;
  core_type                nxt_core;
  logic                    armed_ff;
  logic [2:0]              four_lane_sync_ff;
  logic                    four_lane_held_ff;
  logic                    hold_act;
  logic                    mem_we;
  logic [7:0]              mem_wdata;
  logic [7:0]              mem_rdata;
  logic [4:0]              step;
  logic [3:0]              pins;
  logic                    evt;
  logic                    wp_block;
  sflash_pkg::op_info_type opc_info;

  // ==========================================================================
  // Select tracking
  // ==========================================================================
  // Armed on the first falling select; a select held low through reset arms only when it next falls.
  always_ff @(negedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      armed_ff <= 1'b0;
    end else begin
      armed_ff <= 1'b1;
    end
  end

  // The frame's own rising select hands the finished command to the core domain.
  always_ff @(posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      frame_ff <= '0;
    end else if (rise_ff.complete) begin
      frame_ff.kind   <= rise_ff.kind;
      frame_ff.addr   <= rise_ff.addr;
      frame_ff.nbytes <= rise_ff.nbytes;
      frame_ff.tog    <= ~frame_ff.tog;
    end
  end

  // ==========================================================================
  // Rising edge: capture
  // ==========================================================================
  assign hold_act = ~four_lane_held_ff & ~lane3_in;
  assign pins     = {lane3_in, lane2_in, lane1_in, lane0_in};
  assign step     = sflash_pkg::lane_bits(rise_ff.lanes);
  assign opc_info = sflash_pkg::decode_op({rise_ff.opcode[6:0], lane0_in});

  always_comb begin
    nxt_rise         = rise_ff;
    mem_we           = 1'b0;
    mem_wdata        = 8'h00;
    if (!hold_act) begin
      case (rise_ff.phase)
        sflash_pkg::PH_OPC: begin
          nxt_rise.opcode = {rise_ff.opcode[6:0], lane0_in};
          nxt_rise.bitcnt = rise_ff.bitcnt + 5'h01;
          if (rise_ff.bitcnt == sflash_pkg::OPC_LAST) begin
            nxt_rise.bitcnt = 5'h00;
            nxt_rise.kind   = opc_info.kind;
            nxt_rise.lanes  = opc_info.lanes;
            nxt_rise.rd     = opc_info.rd;
            nxt_rise.wr     = opc_info.wr;
            nxt_rise.col    = 8'h00;
            if (!armed_ff || opc_info.kind == sflash_pkg::K_NONE) begin
              nxt_rise.phase = sflash_pkg::PH_DONE;
            end else if (opc_info.lanes == sflash_pkg::LN_FOUR && !four_lane_held_ff) begin
              nxt_rise.phase = sflash_pkg::PH_DONE;
            end else if (opc_info.has_addr) begin
              nxt_rise.phase = sflash_pkg::PH_ADR;
            end else if (opc_info.rd) begin
              nxt_rise.phase = sflash_pkg::PH_DOUT;
            end else if (opc_info.wr) begin
              nxt_rise.phase = sflash_pkg::PH_DIN;
            end else begin
              nxt_rise.phase    = sflash_pkg::PH_DONE;
              nxt_rise.complete = 1'b1;
            end
          end
        end
        sflash_pkg::PH_ADR: begin
          nxt_rise.addr   = sflash_pkg::shift_in(rise_ff.addr, rise_ff.lanes, pins);
          nxt_rise.bitcnt = 5'(rise_ff.bitcnt + step);
          if (5'(rise_ff.bitcnt + step) == sflash_pkg::ADDR_BITS) begin
            nxt_rise.bitcnt = 5'h00;
            nxt_rise.col    = nxt_rise.addr[7:0];
            if (rise_ff.rd) begin
              nxt_rise.phase = sflash_pkg::PH_DOUT;
            end else if (rise_ff.wr) begin
              nxt_rise.phase = sflash_pkg::PH_DIN;
            end else begin
              nxt_rise.phase    = sflash_pkg::PH_DONE;
              nxt_rise.complete = 1'b1;
            end
          end
        end
        sflash_pkg::PH_DIN: begin
          nxt_rise.opcode = 8'(sflash_pkg::shift_in({16'h0000, rise_ff.opcode},
                                                   rise_ff.lanes, pins));
          nxt_rise.bitcnt = 5'(rise_ff.bitcnt + step);
          if (5'(rise_ff.bitcnt + step) == sflash_pkg::BYTE_BITS) begin
            // The column wraps inside the page, so one program never spans pages.
            nxt_rise.bitcnt   = 5'h00;
            mem_we            = 1'b1;
            mem_wdata         = nxt_rise.opcode;
            nxt_rise.col      = rise_ff.col + 8'h01;
            nxt_rise.complete = 1'b1;
            if (rise_ff.nbytes != sflash_pkg::BYTE_CAP) begin
              nxt_rise.nbytes = rise_ff.nbytes + 9'h001;
            end
          end
        end
        sflash_pkg::PH_DOUT: begin
          nxt_rise.bitcnt = 5'(rise_ff.bitcnt + step);
          if (5'(rise_ff.bitcnt + step) == sflash_pkg::BYTE_BITS) begin
            nxt_rise.bitcnt = 5'h00;
            nxt_rise.col    = rise_ff.col + 8'h01;
          end
        end
        default: begin
          nxt_rise.phase = sflash_pkg::PH_DONE;
        end
      endcase
    end
  end

  // Kept apart from the shifter, so a rising select cannot reopen the pause role of lane3.
  // It moves only on serial clock edges: a new setting needs four edges of a frame.
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      four_lane_sync_ff <= 3'h0;
      four_lane_held_ff <= 1'b0;
    end else begin
      four_lane_sync_ff <= {four_lane_sync_ff[1:0], four_lane_enable};
      if (four_lane_sync_ff[1] == four_lane_sync_ff[2]) begin
        four_lane_held_ff <= four_lane_sync_ff[2];
      end
    end
  end

  // A rising select clears the shifter, so a partial instruction is simply lost.
  always_ff @(posedge sclk or posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      rise_ff <= '0;
    end else if (cs_n) begin
      rise_ff <= '0;
    end else begin
      rise_ff <= nxt_rise;
    end
  end

  sflash_page_mem u_page_mem (
    .clk   (sclk),
    .we    (mem_we),
    .waddr (rise_ff.col),
    .wdata (mem_wdata),
    .raddr (nxt_rise.col),
    .rdata (mem_rdata)
  );

  // ==========================================================================
  // Falling edge: drive
  // ==========================================================================
  always_comb begin
    logic [7:0]  src;
    logic [7:0]  sh;
    logic [63:0] uid_sh;
    uid_sh   = UNIQUE_ID << {rise_ff.col[2:0], 3'h0};
    src      = (rise_ff.kind == sflash_pkg::K_UID) ? uid_sh[63:56] : mem_rdata;
    sh       = src << rise_ff.bitcnt[2:0];
    nxt_fall = '0;
    if (rise_ff.phase == sflash_pkg::PH_DOUT && !hold_act) begin
      case (rise_ff.lanes)
        sflash_pkg::LN_TWO: begin
          nxt_fall.out = {2'b00, sh[7:6]};
          nxt_fall.oe  = 4'h3;
        end
        sflash_pkg::LN_FOUR: begin
          nxt_fall.out = sh[7:4];
          nxt_fall.oe  = 4'hF;
        end
        default: begin
          nxt_fall.out = {2'b00, sh[7], 1'b0};
          nxt_fall.oe  = 4'h2;
        end
      endcase
    end
  end

  always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      fall_ff <= '0;
    end else if (cs_n) begin
      fall_ff <= '0;
    end else begin
      fall_ff <= nxt_fall;
    end
  end

  assign lane0_out = fall_ff.out[0];
  assign lane1_out = fall_ff.out[1];
  assign lane2_out = fall_ff.out[2];
  assign lane3_out = fall_ff.out[3];
  assign lane0_oe  = fall_ff.oe[0];
  assign lane1_oe  = fall_ff.oe[1];
  assign lane2_oe  = fall_ff.oe[2];
  assign lane3_oe  = fall_ff.oe[3];

  // ==========================================================================
  // Core domain: command hand-over and internal cycles
  // ==========================================================================
  // The frame words are only read after the toggle has settled; select must stay
  // high for about four core clocks so the next frame cannot overwrite them.
  assign evt      = (core_ff.tog_s2 == core_ff.tog_s3) && (core_ff.tog_s3 != core_ff.seen);
  assign wp_block = ~four_lane_enable & ~core_ff.wp_held & status_lock_bits[0];

  always_comb begin
    nxt_core         = core_ff;
    nxt_core.start   = 1'b0;
    nxt_core.refused = 1'b0;
    nxt_core.tog_s1  = frame_ff.tog;
    nxt_core.tog_s2  = core_ff.tog_s1;
    nxt_core.tog_s3  = core_ff.tog_s2;
    nxt_core.wp_s1   = lane2_in;
    nxt_core.wp_s2   = core_ff.wp_s1;
    nxt_core.wp_s3   = core_ff.wp_s2;
    if (core_ff.wp_s2 == core_ff.wp_s3) begin
      nxt_core.wp_held = core_ff.wp_s3;
    end
    if (core_ff.busy) begin
      // Counts on the core clock alone, so select changes cannot cut it short.
      nxt_core.cnt = core_ff.cnt - 24'h000001;
      if (core_ff.cnt == 24'h000001) begin
        nxt_core.busy = 1'b0;
      end
    end
    if (evt) begin
      nxt_core.seen = core_ff.tog_s3;
      if (core_ff.busy) begin
        nxt_core.refused = 1'b0;
      end else if (frame_ff.kind == sflash_pkg::K_WRSR && wp_block) begin
        nxt_core.refused = 1'b1;
      end else begin
        nxt_core.start = 1'b1;
        nxt_core.busy  = 1'b1;
        nxt_core.kind  = frame_ff.kind;
        nxt_core.bytes = frame_ff.nbytes;
        nxt_core.area  = frame_ff.addr[13:12];
        nxt_core.addr  = frame_ff.addr;
        nxt_core.cnt   = PROG_CYCLES;
        case (frame_ff.kind)
          sflash_pkg::K_ERASE_4K: begin
            nxt_core.addr = frame_ff.addr & sflash_pkg::MASK_4K;
            nxt_core.cnt  = ERASE_CYCLES;
          end
          sflash_pkg::K_ERASE_32K: begin
            nxt_core.addr = frame_ff.addr & sflash_pkg::MASK_32K;
            nxt_core.cnt  = ERASE_CYCLES;
          end
          sflash_pkg::K_ERASE_64K: begin
            nxt_core.addr = frame_ff.addr & sflash_pkg::MASK_64K;
            nxt_core.cnt  = ERASE_CYCLES;
          end
          sflash_pkg::K_ERASE_ALL: begin
            nxt_core.addr = 24'h000000;
            nxt_core.cnt  = ERASE_CYCLES;
          end
          default: begin
            nxt_core.cnt = PROG_CYCLES;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_ff <= '0;
    end else begin
      core_ff <= nxt_core;
    end
  end

  assign busy                 = core_ff.busy;
  assign op_start             = core_ff.start;
  assign op_kind              = core_ff.kind;
  assign op_addr              = core_ff.addr;
  assign op_bytes             = core_ff.bytes;
  assign otp_area             = core_ff.area;
  assign status_write_refused = core_ff.refused;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_cs_tristate: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_n |-> (fall_ff.oe == 4'h0)) else $error("lane driven while deselected");

  a_busy_runs: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(core_ff.busy) |-> core_ff.busy [*8]) else $error("internal cycle cut short");

  a_start_busy: assert property (@(posedge mclk) disable iff (!rst_n)
    core_ff.start |-> core_ff.busy && !$past(core_ff.busy)) else $error("start without busy");

  a_wp_refuse: assert property (@(posedge mclk) disable iff (!rst_n)
    (evt && !core_ff.busy && frame_ff.kind == sflash_pkg::K_WRSR && wp_block)
    |=> core_ff.refused && !core_ff.start) else $error("protected status write ran");

  a_unarmed_drop: assert property (@(posedge sclk) disable iff (cs_n || !rst_n)
    (!armed_ff && rise_ff.phase == sflash_pkg::PH_OPC && rise_ff.bitcnt == 5'h07
     && !hold_act) |=> (rise_ff.phase == sflash_pkg::PH_DONE) && !rise_ff.complete)
    else $error("instruction taken before select fell");

  a_quad_refused: assert property (@(posedge sclk) disable iff (cs_n || !rst_n)
    (rise_ff.phase == sflash_pkg::PH_OPC && rise_ff.bitcnt == 5'h07 && !hold_act
     && opc_info.lanes == sflash_pkg::LN_FOUR && !four_lane_held_ff)
    |=> rise_ff.phase == sflash_pkg::PH_DONE) else $error("quad taken while disabled");

  a_hold_freeze: assert property (@(posedge sclk) disable iff (cs_n || !rst_n)
    hold_act |=> (rise_ff.phase == $past(rise_ff.phase))
    && (rise_ff.bitcnt == $past(rise_ff.bitcnt))) else $error("shifter moved in pause");

  a_page_cap: assert property (@(posedge sclk) disable iff (cs_n || !rst_n)
    (rise_ff.nbytes == sflash_pkg::BYTE_CAP) |=> (rise_ff.nbytes == sflash_pkg::BYTE_CAP))
    else $error("program byte count past one page");

  a_single_out: assert property (@(negedge sclk) disable iff (cs_n || !rst_n)
    (fall_ff.oe == 4'h2) |-> (rise_ff.lanes == sflash_pkg::LN_ONE)
    && (rise_ff.phase == sflash_pkg::PH_DOUT)) else $error("single lane driven wrongly");

endmodule

// ### sflash_host.sv
// Mode 0 and mode 3 host model that drives the serial flash pins.
module sflash_host (
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] pin,
  input  wire  [3:0] dev_o,
  input  wire  [3:0] dev_e
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] drv = 4'hF;
  logic       mode3 = 1'b0;
  initial sclk = 1'b0;
  initial cs_n = 1'b1;
  // A released lane1 shows the inverse of its last sampled level, never a stale copy.
  assign pin = (dev_e & dev_o) | (~dev_e & drv);
  // ==========================================================================
  // Bit and frame tasks
  // ==========================================================================
  task automatic bit_io(input logic b, output logic r);
    if (mode3) sclk = 1'b0;
    drv[0] = b;
    #3 sclk = 1'b1;
    r = pin[1];
    drv[1] = ~r;
    #3;
    if (!mode3) sclk = 1'b0;
  endtask
  task automatic frame(input logic [7:0] opc, input logic [23:0] a, input int na,
                       input logic [15:0] wd, input int nw, input int nr,
                       output logic [15:0] rd);
    logic r;
    sclk = mode3;
    #7 cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) bit_io(opc[i], r);
    for (int i = na - 1; i >= 0; i--) bit_io(a[i], r);
    for (int i = nw - 1; i >= 0; i--) bit_io(wd[i], r);
    for (int i = 0; i < nr; i++) begin
      bit_io(~drv[0], r);
      rd = {rd[14:0], r};
    end
    #3 cs_n = 1'b1;
    drv[0] = ~drv[0];
  endtask
endmodule

// ### serial_flash_pin_interface_test.sv
// Self-checking bench of the serial flash pin front end.
module serial_flash_pin_interface_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        four_lane = 1'b0;
  logic [1:0]  lock = 2'h1;
  logic [3:0]  o, e, p;
  logic        sclk, cs_n, busy, st, rf, s, r, b;
  logic        oe_seen = 1'b0;
  sflash_pkg::op_kind_type kind;
  logic [23:0] adr;
  logic [8:0]  nb;
  logic [1:0]  area;
  logic [15:0] rd;
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [7:0]  ops [4] = '{8'h31, 8'h32, 8'h33, 8'h34};
  logic [23:0] msk [4] = '{sflash_pkg::MASK_4K, sflash_pkg::MASK_32K, sflash_pkg::MASK_64K, 24'h0};
  always #20 mclk = ~mclk;
  always @(posedge sclk) oe_seen <= oe_seen | (|e);
  sflash_host i_sflash_host (.sclk(sclk), .cs_n(cs_n), .pin(p), .dev_o(o), .dev_e(e));
  sflash_front #(.ERASE_CYCLES(24'h000014), .PROG_CYCLES(24'h00000A),
    .UNIQUE_ID(64'h5AC3_0000_0000_0000)) i_sflash_front (
    .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .lane0_in(p[0]), .lane0_out(o[0]), .lane0_oe(e[0]), .lane1_in(p[1]), .lane1_out(o[1]),
    .lane1_oe(e[1]), .lane2_in(p[2]), .lane2_out(o[2]), .lane2_oe(e[2]), .lane3_in(p[3]),
    .lane3_out(o[3]), .lane3_oe(e[3]), .four_lane_enable(four_lane), .status_lock_bits(lock),
    .busy(busy), .op_start(st), .op_kind(kind), .op_addr(adr), .op_bytes(nb),
    .otp_area(area), .status_write_refused(rf));
  // ==========================================================================
  // Checking and waiting tasks
  // ==========================================================================
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic await();
    s = 1'b0;
    r = 1'b0;
    repeat (40) begin
      @(negedge mclk);
      if (st === 1'b1) b = busy;
      s = s | st;
      r = r | rf;
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    i_sflash_host.frame(8'h21, 24'h1234FE, 24, 16'hA55A, 16, 0, rd);
    await();
    check("prog start", {s, b}, 24'h3);
    check("prog kind", kind, sflash_pkg::K_PROG);
    check("prog addr", adr, 24'h1234FE);
    check("prog bytes", nb, 24'h2);
    i_sflash_host.frame(8'h11, 24'h1234FE, 24, 16'h0, 0, 16, rd);
    check("read data", rd, 24'hA55A);
    #1 check("oe off", e, 24'h0);
    for (int k = 0; k < 4; k++) begin
      i_sflash_host.frame(ops[k], 24'h123456, (k == 3) ? 0 : 24, 16'h0, 0, 0, rd);
      await();
      check("erase start", {s, b}, 24'h3);
      check("erase addr", adr, 24'h123456 & msk[k]);
    end
    i_sflash_host.drv[2] = 1'b0;
    i_sflash_host.frame(8'h61, 24'h0, 0, 16'h00, 8, 0, rd);
    await();
    check("wp refused", {r, s}, 24'h2);
    i_sflash_host.drv[2] = 1'b1;
    oe_seen = 1'b0;
    i_sflash_host.frame(8'h14, 24'h1234FE, 6, 16'h0, 0, 8, rd);
    check("quad refused", oe_seen, 24'h0);
    i_sflash_host.frame(8'h51, 24'h002000, 24, 16'h00A5, 8, 0, rd);
    await();
    check("otp area", {s, kind, area}, {1'b1, sflash_pkg::K_OTP_PROG, 2'h2});
    i_sflash_host.drv[3] = 1'b0;
    i_sflash_host.frame(8'h31, 24'h0, 24, 16'h0, 0, 0, rd);
    await();
    check("pause ignores", s, 24'h0);
    i_sflash_host.drv[3] = 1'b1;
    four_lane = 1'b1;
    i_sflash_host.frame(8'h41, 24'h0, 0, 16'h0, 0, 16, rd);
    check("unique id", rd, 24'h5AC3);
    i_sflash_host.drv[3] = 1'b0;
    i_sflash_host.frame(8'h32, 24'h123456, 24, 16'h0, 0, 0, rd);
    await();
    check("quad pause off", s, 24'h1);
    i_sflash_host.drv[3] = 1'b1;
    four_lane = 1'b0;
    rst_n = 1'b0;
    i_sflash_host.cs_n = 1'b0;
    repeat (2) @(negedge mclk);
    check("reset outputs", {busy, st, rf, kind, area}, 24'h0);
    rst_n = 1'b1;
    i_sflash_host.frame(8'h31, 24'h123456, 24, 16'h0, 0, 0, rd);
    await();
    check("unarmed drop", s, 24'h0);
    i_sflash_host.mode3 = 1'b1;
    i_sflash_host.frame(8'h11, 24'h1234FE, 24, 16'h0, 0, 16, rd);
    check("mode 3 read", rd, 24'hA55A);
    complete_run();
  end
endmodule
